// file: include/ric_pkg.sv
// constants and types for the restart interlock control block
package ric_pkg;
  // register offsets
  localparam logic [7:0] RIC_OFS_CTRL = 8'h00;
  localparam logic [7:0] RIC_OFS_STATUS = 8'h04;
  localparam logic [7:0] RIC_OFS_IRQ_STAT = 8'h08;
  localparam logic [7:0] RIC_OFS_IRQ_MASK = 8'h0c;
  localparam logic [7:0] RIC_OFS_RESP = 8'h10;
  // control fields
  localparam int RIC_CTRL_ALIGN = 0;
  // status fields
  localparam int RIC_ST_OUT = 0;
  localparam int RIC_ST_LOCK_EN = 1;
  localparam int RIC_ST_EDM_EN = 2;
  localparam int RIC_ST_EDM_OPEN = 3;
  localparam int RIC_ST_FREE = 4;
  localparam int RIC_ST_STATE = 8;
  // event fields, same layout in status and mask
  localparam int RIC_IRQ_TRIP = 0;
  localparam int RIC_IRQ_UNLOCK = 1;
  localparam int RIC_IRQ_DISCARD = 2;
  localparam int RIC_IRQ_FAULT = 3;
  localparam int RIC_IRQ_W = 4;
  // reset values
  localparam logic [31:0] RIC_CTRL_RST = 32'h0000_0000;
  localparam logic [7:0] RIC_RESP_RST = 8'h01;
  localparam logic [3:0] RIC_MASK_RST = 4'h0;
  // timing, in milliseconds as specified
  localparam longint RIC_CLK_HZ = 100000000;
  localparam longint RIC_T_MIN_MS = 150;
  localparam longint RIC_T_MAX_MS = 4000;
  localparam longint RIC_T_SC_MS = 30000;
  localparam longint RIC_T_TEST_MS = 100;
  localparam longint RIC_T_SHOW_MS = 2000;
  localparam longint RIC_T_BLINK_MS = 250;
  localparam longint RIC_CYC_MS = RIC_CLK_HZ / 1000;
  localparam longint RIC_MIN_CYC = RIC_T_MIN_MS * RIC_CYC_MS;
  localparam longint RIC_MAX_CYC = RIC_T_MAX_MS * RIC_CYC_MS;
  localparam longint RIC_SC_CYC = RIC_T_SC_MS * RIC_CYC_MS;
  localparam longint RIC_TEST_CYC = RIC_T_TEST_MS * RIC_CYC_MS;
  localparam longint RIC_SHOW_CYC = RIC_T_SHOW_MS * RIC_CYC_MS;
  localparam longint RIC_BLINK_CYC = RIC_T_BLINK_MS * RIC_CYC_MS;
  // sense slot of the shared button and lamp pin
  localparam logic [7:0] RIC_SENSE_LAST = 8'hff;
  localparam logic [7:0] RIC_SENSE_WIN = 8'h10;
  // display patterns
  localparam logic [7:0] RIC_SEG_ALL = 8'hff;
  localparam logic [7:0] RIC_SEG_NONE = 8'h00;
  // operating states
  typedef enum logic [2:0] {
    RIC_S_TEST = 3'b000,
    RIC_S_SHOW = 3'b001,
    RIC_S_LOCKED = 3'b010,
    RIC_S_ON = 3'b011,
    RIC_S_FAULT = 3'b100
  } ric_state_t;
endpackage

// file: verilog/ric_sync.sv
// three-stage synchroniser bank with agreement filter
`timescale 1ns/100ps
`default_nettype none
module ric_sync #(
  parameter int W = 4
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // levels
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  logic [W-1:0] s1_reg;
  logic [W-1:0] s2_reg;
  logic [W-1:0] s3_reg;

  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      // accept a change once stages two and three agree
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          s1_reg[i] <= 1'b0;
          s2_reg[i] <= 1'b0;
          s3_reg[i] <= 1'b0;
          sync_out[i] <= 1'b0;
        end else begin
          s1_reg[i] <= async_in[i];
          s2_reg[i] <= s1_reg[i];
          s3_reg[i] <= s2_reg[i];
          if (s2_reg[i] == s3_reg[i]) begin
            sync_out[i] <= s3_reg[i];
          end
        end
      end
    end
  endgenerate
endmodule
`default_nettype wire

// file: verilog/ric_top.sv
// restart interlock control with apb registers
//
// Chosen here: register access over APB and the address map.
`timescale 1ns/100ps
`default_nettype none
module ric_top #(
  parameter logic [31:0] P_MIN_CYC = 32'(ric_pkg::RIC_MIN_CYC),
  parameter logic [31:0] P_MAX_CYC = 32'(ric_pkg::RIC_MAX_CYC),
  parameter logic [31:0] P_SC_CYC = 32'(ric_pkg::RIC_SC_CYC),
  parameter logic [31:0] P_TEST_CYC = 32'(ric_pkg::RIC_TEST_CYC),
  parameter logic [31:0] P_SHOW_CYC = 32'(ric_pkg::RIC_SHOW_CYC)
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic irq,
  // beam evaluation, same clock
  input wire logic beams_free,
  input wire logic beams_marginal,
  // pins
  input wire logic reset_button_and_lamp_pin_i,
  output logic reset_button_and_lamp_pin_o,
  output logic reset_button_and_lamp_pin_oe_n,
  input wire logic lockout_select_input,
  input wire logic contactor_feedback_input_hi,
  input wire logic contactor_feedback_input_lo,
  // switching outputs and indicators
  output logic safety_output_a,
  output logic safety_output_b,
  output logic main_status_lamp_green,
  output logic main_status_lamp_red,
  output logic lamp_yellow,
  output logic [7:0] seg_data
);
  ric_pkg::ric_state_t state_reg, state_next;
  logic [3:0] pins_sync;
  logic [7:0] sense_reg;
  logic btn_reg, btn_d_reg, lock_en_reg;
  logic [31:0] press_reg, tmr_reg, blink_cnt_reg;
  logic blink_reg;
  logic [31:0] ctrl_reg;
  logic [7:0] resp_reg;
  logic [3:0] irq_stat_reg, irq_mask_reg, irq_evt;
  logic release_p, unlock_p, discard_p, fault_p;
  logic edm_en, edm_open, edm_ok, align, wr_en;
  logic [31:0] rd_next;
  logic err_next;
  // blink period follows the self-test timebase, so both scale together
  localparam logic [31:0] P_BLINK_CYC = 32'(P_TEST_CYC *
    ric_pkg::RIC_T_BLINK_MS / ric_pkg::RIC_T_TEST_MS);

  //////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  ric_sync #(.W(4)) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .async_in({contactor_feedback_input_lo, contactor_feedback_input_hi,
               lockout_select_input, reset_button_and_lamp_pin_i}),
    .sync_out(pins_sync)
  );

  // feedback decode: high off, low closed, neither open
  assign edm_en = !pins_sync[2];
  assign edm_open = !pins_sync[2] && !pins_sync[3];
  assign edm_ok = !edm_en || !edm_open;
  assign align = ctrl_reg[ric_pkg::RIC_CTRL_ALIGN];

  //////////////////////////////////////////////////////////////////////////
  // shared pin: released in a short sense slot, lamp driven otherwise
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sense_reg <= 8'h00;
      btn_reg <= 1'b0;
      lock_en_reg <= 1'b0;
    end else begin
      sense_reg <= (sense_reg == ric_pkg::RIC_SENSE_LAST) ? 8'h00
                   : sense_reg + 8'h01;
      if (sense_reg == ric_pkg::RIC_SENSE_WIN - 8'h01) begin
        btn_reg <= pins_sync[0];
        lock_en_reg <= pins_sync[1];
      end
    end
  end

  // lamp drive, inverse of the switching outputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      reset_button_and_lamp_pin_o <= 1'b1;
      reset_button_and_lamp_pin_oe_n <= 1'b1;
    end else begin
      reset_button_and_lamp_pin_o <= state_next != ric_pkg::RIC_S_ON;
      reset_button_and_lamp_pin_oe_n <=
        (sense_reg + 8'h01) < ric_pkg::RIC_SENSE_WIN ||
        sense_reg == ric_pkg::RIC_SENSE_LAST;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // press duration timer
  assign release_p = btn_d_reg && !btn_reg;
  assign unlock_p = release_p && press_reg >= P_MIN_CYC
                    && press_reg <= P_MAX_CYC;
  assign discard_p = btn_reg && press_reg == P_MAX_CYC;
  assign fault_p = btn_reg && press_reg == P_SC_CYC - 32'h1;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      btn_d_reg <= 1'b0;
      press_reg <= 32'h0;
    end else begin
      btn_d_reg <= btn_reg;
      if (!btn_reg) begin
        press_reg <= 32'h0;
      end else if (press_reg != P_SC_CYC) begin
        press_reg <= press_reg + 32'h1;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // operating state
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      ric_pkg::RIC_S_TEST: begin
        if (tmr_reg == P_TEST_CYC - 32'h1) begin
          state_next = ric_pkg::RIC_S_SHOW;
        end
      end
      ric_pkg::RIC_S_SHOW: begin
        if (tmr_reg == P_SHOW_CYC - 32'h1) begin
          state_next = ric_pkg::RIC_S_LOCKED;
        end
      end
      ric_pkg::RIC_S_LOCKED: begin
        if (fault_p) begin
          state_next = ric_pkg::RIC_S_FAULT;
        end else if (beams_free && edm_ok && (!lock_en_reg || unlock_p)) begin
          state_next = ric_pkg::RIC_S_ON;
        end
      end
      ric_pkg::RIC_S_ON: begin
        if (fault_p) begin
          state_next = ric_pkg::RIC_S_FAULT;
        end else if (!beams_free) begin
          state_next = ric_pkg::RIC_S_LOCKED;
        end
      end
      ric_pkg::RIC_S_FAULT: begin
        if (!btn_reg) begin
          state_next = ric_pkg::RIC_S_LOCKED;
        end
      end
      default: state_next = ric_pkg::RIC_S_FAULT;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= ric_pkg::RIC_S_TEST;
      tmr_reg <= 32'h0;
    end else begin
      state_reg <= state_next;
      tmr_reg <= (state_next != state_reg) ? 32'h0 : tmr_reg + 32'h1;
    end
  end

  // both outputs from one decision, dropped on the next edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      safety_output_a <= 1'b0;
      safety_output_b <= 1'b0;
    end else begin
      safety_output_a <= state_next == ric_pkg::RIC_S_ON;
      safety_output_b <= state_next == ric_pkg::RIC_S_ON;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // blink timebase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      blink_cnt_reg <= 32'h0;
      blink_reg <= 1'b0;
    end else if (blink_cnt_reg == P_BLINK_CYC - 32'h1) begin
      blink_cnt_reg <= 32'h0;
      blink_reg <= !blink_reg;
    end else begin
      blink_cnt_reg <= blink_cnt_reg + 32'h1;
    end
  end

  // indicators and segment display
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      main_status_lamp_green <= 1'b0;
      main_status_lamp_red <= 1'b0;
      lamp_yellow <= 1'b0;
      seg_data <= ric_pkg::RIC_SEG_NONE;
    end else begin
      main_status_lamp_green <= (state_next == ric_pkg::RIC_S_ON) &&
        !(align && beams_marginal && !blink_reg);
      main_status_lamp_red <= state_next == ric_pkg::RIC_S_LOCKED ||
        (state_next == ric_pkg::RIC_S_FAULT && blink_reg);
      lamp_yellow <= state_next == ric_pkg::RIC_S_LOCKED &&
        lock_en_reg && beams_free;
      if (state_next == ric_pkg::RIC_S_TEST) begin
        seg_data <= ric_pkg::RIC_SEG_ALL;
      end else if (state_next == ric_pkg::RIC_S_SHOW) begin
        seg_data <= resp_reg;
      end else if (align && beams_marginal) begin
        seg_data <= blink_reg ? ric_pkg::RIC_SEG_ALL
                    : ric_pkg::RIC_SEG_NONE;
      end else begin
        seg_data <= ric_pkg::RIC_SEG_NONE;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // apb decode, zero wait states, answer registered in setup
  assign wr_en = psel && penable && pready && pwrite;

  always_comb begin
    rd_next = 32'h0;
    err_next = 1'b0;
    unique case (paddr)
      ric_pkg::RIC_OFS_CTRL: rd_next = ctrl_reg;
      ric_pkg::RIC_OFS_STATUS: begin
        rd_next[ric_pkg::RIC_ST_OUT] = safety_output_a;
        rd_next[ric_pkg::RIC_ST_LOCK_EN] = lock_en_reg;
        rd_next[ric_pkg::RIC_ST_EDM_EN] = edm_en;
        rd_next[ric_pkg::RIC_ST_EDM_OPEN] = edm_open;
        rd_next[ric_pkg::RIC_ST_FREE] = beams_free;
        rd_next[ric_pkg::RIC_ST_STATE +: 3] = state_reg;
      end
      ric_pkg::RIC_OFS_IRQ_STAT: rd_next = {28'h0, irq_stat_reg};
      ric_pkg::RIC_OFS_IRQ_MASK: rd_next = {28'h0, irq_mask_reg};
      ric_pkg::RIC_OFS_RESP: rd_next = {24'h0, resp_reg};
      default: err_next = 1'b1;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      prdata <= 32'h0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && !penable;
      prdata <= (psel && !penable && !pwrite) ? rd_next : 32'h0;
      pslverr <= psel && !penable && err_next;
    end
  end

  // software registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg <= ric_pkg::RIC_CTRL_RST;
      resp_reg <= ric_pkg::RIC_RESP_RST;
      irq_mask_reg <= ric_pkg::RIC_MASK_RST;
    end else if (wr_en) begin
      if (paddr == ric_pkg::RIC_OFS_CTRL) begin
        ctrl_reg <= {31'h0, pwdata[ric_pkg::RIC_CTRL_ALIGN]};
      end
      if (paddr == ric_pkg::RIC_OFS_RESP) begin
        resp_reg <= pwdata[7:0];
      end
      if (paddr == ric_pkg::RIC_OFS_IRQ_MASK) begin
        irq_mask_reg <= pwdata[3:0];
      end
    end
  end

  // sticky events, set wins over write-one-to-clear
  always_comb begin
    irq_evt = 4'h0;
    irq_evt[ric_pkg::RIC_IRQ_TRIP] = state_reg == ric_pkg::RIC_S_ON &&
      state_next != ric_pkg::RIC_S_ON;
    irq_evt[ric_pkg::RIC_IRQ_UNLOCK] = unlock_p;
    irq_evt[ric_pkg::RIC_IRQ_DISCARD] = discard_p;
    irq_evt[ric_pkg::RIC_IRQ_FAULT] = fault_p;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_stat_reg <= 4'h0;
      irq <= 1'b0;
    end else begin
      irq_stat_reg <= (irq_stat_reg & ~((wr_en &&
        paddr == ric_pkg::RIC_OFS_IRQ_STAT) ? pwdata[3:0] : 4'h0))
        | irq_evt;
      irq <= |(irq_stat_reg & irq_mask_reg);
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_outputs_paired: assert property (
    safety_output_a == safety_output_b)
    else $error("switching outputs differ");
  a_trip_drop: assert property (
    state_reg == ric_pkg::RIC_S_ON && !beams_free |=> !safety_output_a)
    else $error("outputs not dropped on beam break");
  a_locked_off_red: assert property (
    state_reg == ric_pkg::RIC_S_LOCKED && $stable(state_reg)
    |-> !safety_output_a && main_status_lamp_red)
    else $error("locked but outputs on or red off");
  a_yellow_ready: assert property (
    state_next == ric_pkg::RIC_S_LOCKED && lock_en_reg && beams_free
    |=> lamp_yellow)
    else $error("yellow not lit when ready to unlock");
  a_short_press: assert property (
    release_p && press_reg < P_MIN_CYC |-> !unlock_p)
    else $error("short press accepted");
  a_valid_unlock: assert property (
    state_reg == ric_pkg::RIC_S_LOCKED && unlock_p && beams_free &&
    edm_ok && !fault_p |=> state_reg == ric_pkg::RIC_S_ON [*1] ##1
    safety_output_a || !beams_free)
    else $error("valid unlock did not switch on");
  a_long_discard: assert property (
    release_p && press_reg > P_MAX_CYC |-> !unlock_p)
    else $error("long press accepted");
  a_short_fault: assert property (
    fault_p |=> state_reg == ric_pkg::RIC_S_FAULT)
    else $error("stuck button did not fault");
  a_test_first: assert property (
    state_reg == ric_pkg::RIC_S_TEST |=>
    state_reg inside {ric_pkg::RIC_S_TEST, ric_pkg::RIC_S_SHOW})
    else $error("self test skipped");
  a_lamp_inverse: assert property (
    !reset_button_and_lamp_pin_oe_n |->
    reset_button_and_lamp_pin_o == !safety_output_a)
    else $error("lamp not inverse of outputs");
  a_edm_block: assert property (
    state_reg == ric_pkg::RIC_S_LOCKED && !edm_ok |=> !safety_output_a)
    else $error("switched on with feedback loop open");

  c_unlock: cover property (unlock_p ##1 state_reg == ric_pkg::RIC_S_ON);
  c_fault: cover property (state_reg == ric_pkg::RIC_S_FAULT);
  c_trip: cover property (irq_evt[ric_pkg::RIC_IRQ_TRIP]);
  c_marginal: cover property (
    align && beams_marginal && state_reg == ric_pkg::RIC_S_ON);
endmodule
`default_nettype wire

// file: tb/ric_field_model.sv
// reset button, installer wiring and downstream relay model
`timescale 1ns/100ps
`default_nettype none
module ric_field_model (
  // button and wiring choices
  input wire logic pressed,
  input wire logic bridged,
  input wire logic [1:0] fb_mode,
  // device pins
  input wire logic pin_o,
  input wire logic pin_oe_n,
  output logic pin_i,
  output logic lockout_sel,
  output logic fb_hi,
  output logic fb_lo,
  input wire logic out_a,
  input wire logic out_b,
  output logic relay_on
);
  // shared pin: pulled low when released, button shorts it high
  assign pin_i = pin_oe_n ? pressed : (pin_o | pressed);
  // select tied high, or bridged to the shared pin
  assign lockout_sel = bridged ? pin_i : 1'b1;
  // feedback pin: 0 high, 1 low, 2 floating
  assign fb_hi = (fb_mode == 2'h0);
  assign fb_lo = (fb_mode == 2'h1);
  // relay pulls in only with both channels on
  assign relay_on = out_a & out_b;
endmodule
`default_nettype wire

// file: tb/test_restart_interlock_control.sv
// self-checking bench for the restart interlock control block
`timescale 1ns/100ps
`default_nettype none
module test_restart_interlock_control;
  typedef struct {
    logic [7:0] a;
    logic [31:0] m;
    logic [31:0] x;
    logic e;
  } ric_row_t;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
  logic [7:0] paddr, seg_data;
  logic [31:0] pwdata, prdata;
  logic beams_free, beams_marginal, pin_i, pin_o, pin_oe_n, sel, hi, lo;
  logic out_a, out_b, green, red, yellow, pressed, bridged, relay_on;
  logic [1:0] fb_mode;
  int bad_count = 0;
  int compares = 0;
  ric_row_t rows[5] = '{'{8'h00, 32'hffffffff, 32'h0, 1'b0},
    '{8'h0c, 32'hffffffff, 32'h0, 1'b0}, '{8'h10, 32'hffffffff, 32'h1, 1'b0},
    '{8'h20, 32'hffffffff, 32'h0, 1'b1}, '{8'h04, 32'h71e, 32'h212, 1'b0}};
  ////////////////////////////////////////////////////////////////////////////
  ric_top #(.P_MIN_CYC(32'h12c), .P_MAX_CYC(32'h4b0), .P_SC_CYC(32'hbb8),
    .P_TEST_CYC(32'h14), .P_SHOW_CYC(32'h14)) dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .irq(irq), .beams_free(beams_free),
    .beams_marginal(beams_marginal), .reset_button_and_lamp_pin_i(pin_i),
    .reset_button_and_lamp_pin_o(pin_o),
    .reset_button_and_lamp_pin_oe_n(pin_oe_n), .lockout_select_input(sel),
    .contactor_feedback_input_hi(hi), .contactor_feedback_input_lo(lo),
    .safety_output_a(out_a), .safety_output_b(out_b),
    .main_status_lamp_green(green), .main_status_lamp_red(red),
    .lamp_yellow(yellow), .seg_data(seg_data));
  ric_field_model field (.pressed(pressed), .bridged(bridged),
    .fb_mode(fb_mode), .pin_o(pin_o), .pin_oe_n(pin_oe_n), .pin_i(pin_i),
    .lockout_sel(sel), .fb_hi(hi), .fb_lo(lo), .out_a(out_a), .out_b(out_b),
    .relay_on(relay_on));
  ////////////////////////////////////////////////////////////////////////////
  // 100 mhz clock
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  // verdict and end of run
  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic hold(input int n);
    repeat (n) @(posedge pclk);
  endtask
  // one apb transfer, entered just after a rising edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] q, output logic e);
    int n;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // one idle edge, so the next setup never lands in this time step
    @(posedge pclk);
    if (n >= 50) begin
      bad_count++;
      complete_run();
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] m,
      input logic [31:0] x);
    logic [31:0] q;
    logic e;
    apb(1'b0, a, 32'h0, q, e);
    chk(q & m, x);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, d, q, e);
  endtask
  // poll the state field with a bounded count
  task automatic wait_state(input logic [2:0] s);
    logic [31:0] q;
    logic e;
    int n;
    n = 0;
    do begin
      apb(1'b0, 8'h04, 32'h0, q, e);
      n++;
    end while (q[10:8] !== s && n < 200);
    chk(32'(q[10:8]), 32'(s));
  endtask
  task automatic press(input int len);
    pressed <= 1'b1;
    hold(len);
    pressed <= 1'b0;
    hold(600);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    logic [31:0] q;
    logic e;
    int bad;
    logic [3:0] seen;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    beams_free = 1'b1;
    beams_marginal = 1'b0;
    pressed = 1'b0;
    bridged = 1'b0;
    fb_mode = 2'h0;
    presetn = 0;
    hold(3);
    presetn <= 1'b1;
    hold(2);
    chk(32'(seg_data), 32'hff);
    wait_state(3'h1);
    hold(2);
    chk(32'(seg_data), 32'(ric_pkg::RIC_RESP_RST));
    wait_state(3'h2);
    foreach (rows[i]) begin
      apb(1'b0, rows[i].a, 32'h0, q, e);
      chk(q & rows[i].m, rows[i].x);
      chk(32'(e), 32'(rows[i].e));
    end
    chk(32'({out_a, out_b, green, red, yellow}), 32'h3);
    chk(32'(pin_o), 32'h1);
    $display("done: reset and register table");
    wr(8'h0c, 32'hf);
    press(100);
    wait_state(3'h2);
    press(700);
    chk(32'({out_a, out_b, green, red, relay_on}), 32'h1d);
    chk(32'({pin_o, irq}), 32'h1);
    rd(8'h08, 32'hf, 32'h2);
    wr(8'h08, 32'h2);
    hold(2);
    chk(32'(irq), 32'h0);
    bad = 0;
    repeat (40) begin
      @(posedge pclk);
      if (green !== 1'b1) bad++;
    end
    chk(32'(bad), 32'h0);
    $display("done: unlock");
    wr(8'h00, 32'h1);
    beams_marginal <= 1'b1;
    seen = 4'h0;
    hold(2);
    repeat (120) begin
      @(posedge pclk);
      seen |= {seg_data == 8'hff, seg_data == 8'h00, green, !green};
    end
    chk(32'(seen), 32'hf);
    beams_marginal <= 1'b0;
    wr(8'h00, 32'h0);
    $display("done: alignment display");
    beams_free <= 1'b0;
    hold(1);
    #1;
    chk(32'({out_a, out_b}), 32'h0);
    hold(1);
    beams_free <= 1'b1;
    hold(50);
    chk(32'({out_a, out_b, red}), 32'h1);
    rd(8'h08, 32'hf, 32'h1);
    wr(8'h08, 32'hf);
    press(2000);
    rd(8'h08, 32'hf, 32'h4);
    wait_state(3'h2);
    wr(8'h08, 32'hf);
    pressed <= 1'b1;
    hold(3600);
    wait_state(3'h4);
    chk(32'({out_a, out_b}), 32'h0);
    pressed <= 1'b0;
    hold(600);
    wait_state(3'h2);
    $display("done: trip, discard and fault");
    wr(8'h0c, 32'h0);
    hold(2);
    chk(32'(irq), 32'h0);
    wr(8'h0c, 32'h8);
    hold(2);
    chk(32'(irq), 32'h1);
    wr(8'h08, 32'hf);
    fb_mode <= 2'h1;
    hold(20);
    rd(8'h04, 32'hc, 32'h4);
    fb_mode <= 2'h2;
    hold(20);
    rd(8'h04, 32'hc, 32'hc);
    fb_mode <= 2'h0;
    hold(20);
    rd(8'h04, 32'hc, 32'h0);
    bridged <= 1'b1;
    hold(700);
    rd(8'h04, 32'h2, 32'h0);
    chk(32'({out_a, out_b}), 32'h3);
    $display("done: feedback, masking and bridged select");
    complete_run();
  end
endmodule
`default_nettype wire
